// ===== logic/ichp_map.svh
// constants for the controller end of the cable handshake port
// assumes one 200 MHz clock; cable pins are active low and asynchronous
// Behaviour
// - every cable signal is active low
// - bulk channel: eight data plus parity
// - command-status channel: eight bits, both directions
// - bit seven msb, bit zero lsb
// - all-floating data and parity flags parity error
// - request out arrives as request in
// - sender requests, receiver answers with ack
// - cs sender drops request on ack, drives between
// - receiver holds ack until latched and request gone
// - sender waits ack release before next byte
// - bulk sender loads, then drives and requests
// - bulk direction agreed beforehand, never both drive
// - on host request, drop own request, ack
// - after yielding, receive normally to the end
// - never assert request and ack together
// - wait unbounded; ack accepts, request refuses
// - no new byte until ack released
// - hard reset holds handshake outputs inactive
`ifndef ICHP_MAP_SVH
`define ICHP_MAP_SVH
`define ICHP_BYTE_W   8
`define ICHP_PIN_IDLE 1'b1
`define ICHP_BYTE_0   8'h00
`define ICHP_BYTE_IDLE 8'hff
`define ICHP_WORD_0   9'h000
`define ICHP_WORD_IDLE 9'h1ff
`endif

// ===== logic/ichp_pkg.sv
// types for the controller end of the cable handshake port
// assumes ichp_map.svh is on the include path
package ichp_pkg;
  // one-hot handshake states, shared by both channels
  typedef enum logic [4:0] {
    HS_IDLE  = 5'b00001,
    HS_SREQ  = 5'b00010,
    HS_SWAIT = 5'b00100,
    HS_RACK  = 5'b01000,
    HS_RDONE = 5'b10000
  } ichp_hs_type;
endpackage

// ===== logic/ichp_port.sv
// controller end of the cable port: command-status and bulk data handshakes
// assumes cable pins are open lines pulled high; all pin inputs asynchronous
`timescale 1ns/1ps
`include "ichp_map.svh"

module ichp_port (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       hardResetN,
  // command-status cable pins, active low
  input  wire logic       csReqInN,
  input  wire logic       csAckInN,
  output logic            csReqOutN,
  output logic            csAckOutN,
  input  wire logic [7:0] csDataInN,
  output logic      [7:0] csDataOutN,
  output logic            csDataOe,
  // bulk data cable pins, active low
  input  wire logic       dpReqInN,
  input  wire logic       dpAckInN,
  output logic            dpReqOutN,
  output logic            dpAckOutN,
  input  wire logic [8:0] dpDataInN,
  output logic      [8:0] dpDataOutN,
  output logic            dpDataOe,
  // user side, status send
  input  wire logic       stSend,
  input  wire logic [7:0] stByte,
  output logic            stBusy,
  output logic            stAccepted,
  output logic            stRefused,
  // user side, command receive
  output logic            cmdValid,
  output logic      [7:0] cmdByte,
  // user side, bulk channel; dpDirTx agreed over command-status
  input  wire logic       dpDirTx,
  input  wire logic       dpSend,
  input  wire logic [7:0] dpTxByte,
  output logic            dpBusy,
  output logic            dpRxValid,
  output logic      [7:0] dpRxByte,
  output logic            dpParErr
);
  import ichp_pkg::*;

  // two-flop synchronisers; first stage read only by second stage
  logic [21:0] sync1_q, sync2_q;
  logic        hardReset;
  logic        csReqIn;
  logic        csAckIn;
  logic        dpReqIn;
  logic        dpAckIn;
  logic [7:0]  csDin;
  logic [8:0]  dpDin;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_q <= '1;
      sync2_q <= '1;
    end
    else
    begin
      sync1_q <= {hardResetN, csReqInN, csAckInN, dpReqInN, dpAckInN, csDataInN, dpDataInN};
      sync2_q <= sync1_q;
    end
  end
  // active-low pins turned to active-high meaning, bit 7 kept msb
  // packing from the top: hard reset, four handshakes, cs byte, bulk word
  assign hardReset = ~sync2_q[21];
  assign csReqIn   = ~sync2_q[20];
  assign csAckIn   = ~sync2_q[19];
  assign dpReqIn   = ~sync2_q[18];
  assign dpAckIn   = ~sync2_q[17];
  assign csDin     = ~sync2_q[16:9];
  assign dpDin     = ~sync2_q[8:0];

  // command-status channel state
  ichp_hs_type cs_q, cs_d;
  logic [7:0]  csOut_q, csOut_d; // held at pin level, already inverted
  logic [7:0]  cmd_q, cmd_d;
  logic        csOe_q, csOe_d;
  logic        cmdV_q, cmdV_d;
  logic        acc_q, acc_d;
  logic        ref_q, ref_d;

  // command-status next state: host always wins contention
  always_comb
  begin
    cs_d    = cs_q;
    csOut_d = csOut_q;
    csOe_d  = csOe_q;
    cmd_d   = cmd_q;
    cmdV_d  = 1'b0;
    acc_d   = 1'b0;
    ref_d   = 1'b0;
    unique case (cs_q)
      HS_IDLE:
        if (csReqIn)
          cs_d = HS_RACK;
        else if (stSend)
        begin
          csOut_d = ~stByte;                 // pin level
          csOe_d  = 1'b1;
          cs_d    = HS_SREQ;
        end
      // host request beats ours even if its ack is already on the way
      HS_SREQ:
        if (csReqIn)
        begin
          csOe_d = 1'b0;                     // yield, drivers off
          ref_d  = 1'b1;
          cs_d   = HS_RACK;
        end
        else if (csAckIn)
        begin
          acc_d = 1'b1;
          cs_d  = HS_SWAIT;                  // drop request
        end
      HS_SWAIT:
        if (!csAckIn)
        begin
          csOe_d = 1'b0;
          cs_d   = HS_IDLE;
        end
      HS_RACK:
        if (!csReqIn)
        begin
          cmd_d  = csDin;                    // latch after request gone
          cmdV_d = 1'b1;
          cs_d   = HS_RDONE;
        end
      // byte already latched; ack held this one cycle, then released
      HS_RDONE:
        cs_d = HS_IDLE;                      // ack released at the end of this cycle
      default:
        cs_d = HS_IDLE;
    endcase
    if (hardReset)
    begin
      cs_d   = HS_IDLE;
      csOe_d = 1'b0;
    end
  end

  // registers only; reset leaves the byte lines at the released level
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cs_q    <= HS_IDLE;
      csOut_q <= `ICHP_BYTE_IDLE;
      csOe_q  <= 1'b0;
      cmd_q   <= `ICHP_BYTE_0;
      cmdV_q  <= 1'b0;
      acc_q   <= 1'b0;
      ref_q   <= 1'b0;
    end
    else
    begin
      cs_q    <= cs_d;
      csOut_q <= csOut_d;
      csOe_q  <= csOe_d;
      cmd_q   <= cmd_d;
      cmdV_q  <= cmdV_d;
      acc_q   <= acc_d;
      ref_q   <= ref_d;
    end
  end

  // bulk channel state; direction is fixed by the user from prior exchanges
  ichp_hs_type dp_q, dp_d;
  logic [8:0]  dpOut_q, dpOut_d;
  logic [7:0]  dpRx_q, dpRx_d;
  logic        dpOe_q, dpOe_d;
  logic        dpRxV_q, dpRxV_d;
  logic        par_q, par_d;

  // odd parity for the outgoing word; all-released lines read as zero here
  logic        txPar;
  logic        rxFloat;
  assign txPar   = ~^dpTxByte;
  assign rxFloat = (dpDin == `ICHP_WORD_0);

  always_comb
  begin
    dp_d    = dp_q;
    dpOut_d = dpOut_q;
    dpOe_d  = dpOe_q;
    dpRx_d  = dpRx_q;
    dpRxV_d = 1'b0;
    par_d   = par_q;
    unique case (dp_q)
      HS_IDLE:
        if (dpDirTx && dpSend)
        begin
          dpOut_d = ~{txPar, dpTxByte};      // pin level, loaded first
          dp_d    = HS_SWAIT;
        end
        else if (!dpDirTx && dpReqIn)
          dp_d = HS_RACK;
      HS_SWAIT:
        begin
          dpOe_d = 1'b1;                     // drive with request
          dp_d   = HS_SREQ;
        end
      HS_SREQ:
        if (dpAckIn)
          dp_d = HS_RDONE;                   // request dropped on ack
      HS_RDONE:
        if (dpDirTx ? !dpAckIn : 1'b1)
        begin
          dpOe_d = 1'b0;
          dp_d   = HS_IDLE;
        end
      // latch from the synchronised lines; the sender still drives them
      HS_RACK:
        if (!dpReqIn)
        begin
          dpRx_d  = dpDin[7:0];
          dpRxV_d = 1'b1;
          par_d   = rxFloat || !(^dpDin);    // even count or floating
          dp_d    = HS_RDONE;                // ack held one more cycle
        end
      default:
        dp_d = HS_IDLE;
    endcase
    if (hardReset)
    begin
      dp_d   = HS_IDLE;
      dpOe_d = 1'b0;
    end
  end

  // registers only; reset leaves the bulk lines at the released level
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dp_q    <= HS_IDLE;
      dpOut_q <= `ICHP_WORD_IDLE;
      dpOe_q  <= 1'b0;
      dpRx_q  <= `ICHP_BYTE_0;
      dpRxV_q <= 1'b0;
      par_q   <= 1'b0;
    end
    else
    begin
      dp_q    <= dp_d;
      dpOut_q <= dpOut_d;
      dpOe_q  <= dpOe_d;
      dpRx_q  <= dpRx_d;
      dpRxV_q <= dpRxV_d;
      par_q   <= par_d;
    end
  end

  // pin outputs registered; request and ack come from exclusive states
  // decoding the next state keeps pins in step with the engines, no lag
  logic        csReqO_q, csAckO_q;
  logic        dpReqO_q, dpAckO_q;
  logic        stBusy_q, dpBusy_q;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      csReqO_q <= `ICHP_PIN_IDLE;
      csAckO_q <= `ICHP_PIN_IDLE;
      dpReqO_q <= `ICHP_PIN_IDLE;
      dpAckO_q <= `ICHP_PIN_IDLE;
      stBusy_q <= 1'b0;
      dpBusy_q <= 1'b0;
    end
    else
    begin
      csReqO_q <= ~(cs_d == HS_SREQ);
      // ack spans the latch cycle too, so it only falls once the byte is held
      csAckO_q <= ~(cs_d == HS_RACK || cs_d == HS_RDONE);
      dpReqO_q <= ~(dp_d == HS_SREQ);
      dpAckO_q <= ~(dp_d == HS_RACK || (dp_d == HS_RDONE && !dpDirTx));
      stBusy_q <= ~(cs_d == HS_IDLE);
      dpBusy_q <= ~(dp_d == HS_IDLE);
    end
  end

  // every output is a plain register, no gate after the flop
  assign csReqOutN  = csReqO_q;
  assign csAckOutN  = csAckO_q;
  assign csDataOutN = csOut_q;               // held inverted
  assign csDataOe   = csOe_q;
  assign dpReqOutN  = dpReqO_q;
  assign dpAckOutN  = dpAckO_q;
  assign dpDataOutN = dpOut_q;
  assign dpDataOe   = dpOe_q;
  assign stBusy     = stBusy_q;
  assign stAccepted = acc_q;
  assign stRefused  = ref_q;
  assign cmdValid   = cmdV_q;
  assign cmdByte    = cmd_q;
  assign dpBusy     = dpBusy_q;
  assign dpRxValid  = dpRxV_q;
  assign dpRxByte   = dpRx_q;
  assign dpParErr   = par_q;

endmodule // ichp_port

// ===== testbench/ichp_port_assertions.sv
// checker for the controller end of the cable port
// assumes binding to ichp_port; pins sampled raw, ahead of the two-flop sync
`timescale 1ns/1ps
module ichp_port_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hardResetN,
  input wire logic csReqInN,
  input wire logic csAckInN,
  input wire logic csReqOutN,
  input wire logic csAckOutN,
  input wire logic csDataOe,
  input wire logic dpReqOutN,
  input wire logic dpDataOe,
  input wire logic cmdValid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // low is asserted; windows allow for the sync lag on incoming pins
  a_cs_excl: assert property (csReqOutN || csAckOutN) else $error("req with ack");
  a_cs_drive: assert property (!csReqOutN |-> csDataOe) else $error("cs undriven");
  a_dp_drive: assert property (!dpReqOutN |-> dpDataOe) else $error("dp undriven");
  a_host_wins: assert property ((!csReqInN && hardResetN) [*4] |-> !csAckOutN && csReqOutN)
    else $error("no yield");
  a_ack_hold: assert property (!csAckOutN && !csReqInN |=> !csAckOutN) else $error("ack early");
  a_wait_rel: assert property (csReqOutN && !csAckInN |=> csReqOutN) else $error("req early");
  a_cmd_latch: assert property (cmdValid |-> !csAckOutN && csReqInN) else $error("bad latch");
  a_hard_quiet: assert property (!hardResetN [*4] |-> csReqOutN && csAckOutN && dpReqOutN)
    else $error("hard reset ignored");
endmodule // ichp_port_assertions
bind ichp_port ichp_port_assertions chk_u (
  .clk        (clk),
  .resetn     (resetn),
  .hardResetN (hardResetN),
  .csReqInN   (csReqInN),
  .csAckInN   (csAckInN),
  .csReqOutN  (csReqOutN),
  .csAckOutN  (csAckOutN),
  .csDataOe   (csDataOe),
  .dpReqOutN  (dpReqOutN),
  .dpDataOe   (dpDataOe),
  .cmdValid   (cmdValid)
);

// ===== testbench/ichp_host_model.sv
// host end of one handshake channel, used for both channels
// assumes active-low pins; data lines float high when nobody drives
`timescale 1ns/1ps
module ichp_host_model #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         devReqN,
  input  wire logic         devAckN,
  input  wire logic [W-1:0] devOutN,
  input  wire logic         devOe,
  output logic              reqN,
  output logic              ackN,
  output logic      [W-1:0] busN
);
  logic [W-1:0] outN = '1;
  logic [W-1:0] got = '0;
  logic         drv = 1'b0;
  logic         accept = 1'b1;
  int           dly = 0;
  int           stalls = 0; // handshake waits that ran out of cycles
  initial reqN = 1'b1;
  initial ackN = 1'b1;
  // wire level; a released line reads high
  assign busN = devOe ? devOutN : (drv ? outN : '1);
  // receive unless told to ignore; never while sending
  always @(posedge clk)
    if (!devReqN && accept && reqN && ackN)
    begin
      repeat (dly) @(posedge clk);
      ackN <= 1'b0;
      for (int i = 0; i < 99 && !devReqN; i++) @(posedge clk);
      if (!devReqN) stalls++;
      got = ~busN; // taken once the request is gone or the 99-cycle wait runs out
      ackN <= 1'b1;
      @(posedge clk);
    end
  // send at any time after the last transfer ended
  task automatic send(input logic [W-1:0] b);
    outN <= ~b;
    drv <= 1'b1;
    reqN <= 1'b0;
    for (int i = 0; i < 99 && devAckN; i++) @(posedge clk);
    if (devAckN) stalls++;
    reqN <= 1'b1;
    for (int i = 0; i < 99 && !devAckN; i++) @(posedge clk);
    if (!devAckN) stalls++;
    drv <= 1'b0;
  endtask
endmodule // ichp_host_model

// ===== testbench/ichp_port_tb_top.sv
// self-checking bench for the controller cable port
// assumes the bound checker and a host model on each channel
`timescale 1ns/1ps
module ichp_port_tb_top;
  import ichp_pkg::*;
  typedef struct packed { logic [7:0] b; logic bad; } ichp_row_type;
  logic         clk = 1'b0;
  logic         resetn = 1'b0;
  logic         hardResetN = 1'b1;
  logic         stSend = 1'b0;
  logic         dpDirTx = 1'b0;
  logic         dpSend = 1'b0;
  logic   [7:0] stByte = 8'h00;
  logic   [7:0] dpTxByte = 8'h96;
  logic   [7:0] lastCmd;
  logic   [8:0] lastRx;
  wire          csReqInN, csAckInN, csReqOutN, csAckOutN, csDataOe, stBusy, stAccepted;
  wire          dpReqInN, dpAckInN, dpReqOutN, dpAckOutN, dpDataOe, dpBusy, dpRxValid;
  wire          stRefused, cmdValid, dpParErr;
  wire    [7:0] csDataInN, csDataOutN, cmdByte, dpRxByte;
  wire    [8:0] dpDataInN, dpDataOutN;
  int           mismatches = 0;
  int           comparisons = 0;
  int           accCnt = 0;
  int           refCnt = 0;
  // byte sent and whether the receiver should see a parity fault
  ichp_row_type rows [4] = '{'{8'h80, 1'b0}, '{8'h01, 1'b1}, '{8'ha5, 1'b0}, '{8'h00, 1'b1}};
  ichp_port dut_u (
    .clk        (clk),
    .resetn     (resetn),
    .hardResetN (hardResetN),
    .csReqInN   (csReqInN),
    .csAckInN   (csAckInN),
    .csReqOutN  (csReqOutN),
    .csAckOutN  (csAckOutN),
    .csDataInN  (csDataInN),
    .csDataOutN (csDataOutN),
    .csDataOe   (csDataOe),
    .dpReqInN   (dpReqInN),
    .dpAckInN   (dpAckInN),
    .dpReqOutN  (dpReqOutN),
    .dpAckOutN  (dpAckOutN),
    .dpDataInN  (dpDataInN),
    .dpDataOutN (dpDataOutN),
    .dpDataOe   (dpDataOe),
    .stSend     (stSend),
    .stByte     (stByte),
    .stBusy     (stBusy),
    .stAccepted (stAccepted),
    .stRefused  (stRefused),
    .cmdValid   (cmdValid),
    .cmdByte    (cmdByte),
    .dpDirTx    (dpDirTx),
    .dpSend     (dpSend),
    .dpTxByte   (dpTxByte),
    .dpBusy     (dpBusy),
    .dpRxValid  (dpRxValid),
    .dpRxByte   (dpRxByte),
    .dpParErr   (dpParErr)
  );
  ichp_host_model #(.W(8)) hcs_u (.clk(clk), .devReqN(csReqOutN), .devAckN(csAckOutN),
    .devOutN(csDataOutN), .devOe(csDataOe), .reqN(csReqInN), .ackN(csAckInN), .busN(csDataInN));
  ichp_host_model #(.W(9)) hdp_u (.clk(clk), .devReqN(dpReqOutN), .devAckN(dpAckOutN),
    .devOutN(dpDataOutN), .devOe(dpDataOe), .reqN(dpReqInN), .ackN(dpAckInN), .busN(dpDataInN));
  always #2.5 clk = ~clk;
  // catch single-cycle pulses from the user side
  always @(posedge clk)
  begin
    if (cmdValid === 1'b1) lastCmd <= cmdByte;
    if (dpRxValid === 1'b1) lastRx <= {dpParErr, dpRxByte};
    if (stAccepted === 1'b1) accCnt <= accCnt + 1;
    if (stRefused === 1'b1) refCnt <= refCnt + 1;
  end
  task automatic chk(input logic ok);
    comparisons++;
    if (ok !== 1'b1) $display("BAD %0t check %0d", $time, comparisons);
    if (ok !== 1'b1) mismatches++;
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // bounded wait for both engines; running out ends the run
  task automatic waitIdle;
    @(posedge clk);
    for (int i = 0; i < 99 && (stBusy !== 1'b0 || dpBusy !== 1'b0); i++) @(posedge clk);
    if (stBusy !== 1'b0 || dpBusy !== 1'b0)
    begin
      $display("BAD %0t engine stuck busy", $time);
      mismatches++;
      results();
    end
  endtask
  task automatic pulse(input logic [7:0] b);
    stByte <= b;
    stSend <= 1'b1;
    @(posedge clk);
    stSend <= 1'b0;
  endtask
  initial
  begin
    #150000;
    $display("BAD %0t run timed out", $time);
    mismatches++;
    results();
  end
  initial
  begin
    hdp_u.dly = 4;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk(csReqOutN === 1'b1 && csAckOutN === 1'b1 && dpDataOe === 1'b0);
    $display("reset test done");
    foreach (rows[i])
    begin
      hcs_u.send(rows[i].b);
      hdp_u.send({rows[i].bad ^ ~^rows[i].b, rows[i].b});
      @(posedge clk);
      chk(lastCmd === rows[i].b);
      chk(lastRx === {rows[i].bad, rows[i].b});
    end
    $display("table test done");
    pulse(8'h3c);
    waitIdle();
    chk(accCnt == 1 && hcs_u.got === 8'h3c);
    dpDirTx <= 1'b1;
    dpSend <= 1'b1;
    @(posedge clk);
    dpSend <= 1'b0;
    waitIdle();
    chk(hdp_u.got === 9'h196);
    $display("send test done");
    hcs_u.accept = 1'b0;
    pulse(8'hc4);
    repeat (4) @(posedge clk);
    hcs_u.send(8'h5a);
    waitIdle();
    chk(refCnt == 1 && lastCmd === 8'h5a && accCnt == 1);
    $display("contention test done");
    pulse(8'h34);
    repeat (4) @(posedge clk);
    chk(csReqOutN === 1'b0);
    hardResetN <= 1'b0;
    repeat (5) @(posedge clk);
    chk(csReqOutN === 1'b1 && csDataOe === 1'b0);
    hardResetN <= 1'b1;
    hcs_u.accept = 1'b1;
    waitIdle();
    chk(hcs_u.stalls == 0 && hdp_u.stalls == 0);
    $display("hard reset test done");
    results();
  end
endmodule // ichp_port_tb_top
